/* File: rtl/rep_pkg.sv */
package rep_pkg;

   // ****************************************************************
   // geometry defaults
   // ****************************************************************
   localparam int NUM_PODS = 4;
   localparam int POD_AW   = 18;
   localparam int TA_W     = 20;
   localparam int GROUP_ID = 0;

   // ****************************************************************
   // register byte offsets
   // ****************************************************************
   localparam logic [7:0] REG_CTRL      = 8'h00;
   localparam logic [7:0] REG_BASE      = 8'h04;
   localparam logic [7:0] REG_ORDER     = 8'h08;
   localparam logic [7:0] REG_GROUP     = 8'h0C;
   localparam logic [7:0] REG_INSP_ADDR = 8'h10;
   localparam logic [7:0] REG_INSP_DATA = 8'h14;
   localparam logic [7:0] REG_MBX_ADDR  = 8'h18;
   localparam logic [7:0] REG_MBX_DATA  = 8'h1C;
   localparam logic [7:0] REG_STATUS    = 8'h20;

   // ****************************************************************
   // control field positions
   // ****************************************************************
   localparam int CTRL_WRITABLE_BIT = 0;
   localparam int CTRL_STATIC_BIT   = 1;
   localparam int CTRL_TYPE_LSB     = 2;
   localparam int CTRL_WSIZE_LSB    = 5;
   localparam int CTRL_COUNT_LSB    = 7;
   localparam int CTRL_ORDER_BIT    = 10;
   localparam int ORDER_NIB         = 4;

   // ****************************************************************
   // values after reset
   // ****************************************************************
   localparam logic [31:0] CTRL_RST  = 32'h0000_0080;
   localparam logic [31:0] BASE_RST  = 32'h0000_0000;
   localparam logic [31:0] ORDER_RST = 32'h7654_3210;
   localparam logic [31:0] GROUP_RST = 32'h0000_0000;

   // ****************************************************************
   // emulated rom geometry, selected by size and width
   // ****************************************************************
   typedef enum logic [2:0] {
      ROM_32KX8,
      ROM_64KX8,
      ROM_128KX8,
      ROM_256KX8,
      ROM_512KX8,
      ROM_64KX16,
      ROM_128KX16,
      ROM_256KX16
   } rep_romtype_t;

   // log2 of bytes held by one pod for each type
   localparam logic [4:0] ROM_DEPTH_LG [8] = '{5'h0F, 5'h10, 5'h11, 5'h12,
                                              5'h12, 5'h10, 5'h11, 5'h12};
   localparam logic [7:0] ROM_X16_MASK  = 8'hE0;
   localparam logic [7:0] ROM_PAIR_MASK = 8'hF0;
   localparam logic [7:0] ROM_RO_MASK   = 8'h90;

endpackage : rep_pkg

/* File: rtl/rep_mem_if.sv */
`timescale 1ns/1ps
interface rep_mem_if #(parameter int AW = 18);
   logic [AW-1:0] aAddr;
   logic          aWe;
   logic [7:0]    aWdata;
   logic [7:0]    aRdata;
   logic [AW-1:0] bAddr;
   logic          bWe;
   logic [7:0]    bWdata;
   logic [7:0]    bRdata;

   modport mem (input aAddr, aWe, aWdata, bAddr, bWe, bWdata, output aRdata, bRdata);
   modport ctl (output aAddr, aWe, aWdata, bAddr, bWe, bWdata, input aRdata, bRdata);
endinterface : rep_mem_if

/* File: rtl/rep_pod_mem.sv */
`timescale 1ns/1ps
module rep_pod_mem #(
   parameter int AW = 18
) (
   input wire logic mclk,
   rep_mem_if.mem   memPort
);

   // ****************************************************************
   // one byte-wide pod, target port a and software port b
   // ****************************************************************
   logic [7:0] store [2**AW];
   logic [7:0] aRd_ff;
   logic [7:0] bRd_ff;

   // port b is written after port a, so a mailbox write wins a collision
   always_ff @(posedge mclk)
   begin
      if (memPort.aWe)
      begin
         store[memPort.aAddr] <= memPort.aWdata;
      end
      if (memPort.bWe)
      begin
         store[memPort.bAddr] <= memPort.bWdata;
      end
      aRd_ff <= store[memPort.aAddr];
      bRd_ff <= store[memPort.bAddr];
   end

   assign memPort.aRdata = aRd_ff;
   assign memPort.bRdata = bRd_ff;

endmodule : rep_pod_mem

/* File: rtl/rep_pod_map.sv */
// Chosen here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module rep_pod_map #(
   parameter int NUM_PODS = rep_pkg::NUM_PODS,
   parameter int POD_AW   = rep_pkg::POD_AW,
   parameter int TA_W     = rep_pkg::TA_W,
   parameter int GROUP_ID = rep_pkg::GROUP_ID
) (
   input  wire logic            mclk,
   input  wire logic            rst_n,
   input  wire logic [7:0]      regAddr,
   input  wire logic [31:0]     regWdata,
   input  wire logic            regWr,
   input  wire logic            regRd,
   output logic      [31:0]     regRdata,
   input  wire logic [TA_W-1:0] tgtAddr,
   input  wire logic [31:0]     tgtDataIn,
   output logic      [31:0]     tgtDataOut,
   output logic                 tgtDataOe,
   input  wire logic            tgtCeN,
   input  wire logic            tgtOeN,
   input  wire logic            tgtPodWrN,
   input  wire logic            tgtExtWrN
);

   localparam int PID_W = (NUM_PODS > 1) ? $clog2(NUM_PODS) : 1;

   // ****************************************************************
   // pod mapping
   // ****************************************************************
   // returns {hit, lane} of one pod for a word address
   function automatic logic [2:0] map_pod(
      input logic [TA_W-1:0]  word,
      input logic [PID_W-1:0] pod,
      input logic [1:0]       lgL,
      input logic [4:0]       dlg,
      input logic [3:0]       used,
      input logic [31:0]      order,
      input logic             useOrder
   );
      logic [TA_W-1:0]  rng;
      logic [2:0]       res;
      logic [PID_W-1:0] who;
      logic [1:0]       lmask;
      rng   = word >> dlg;
      res   = 3'h0;
      lmask = 2'(3'(3'h1 << lgL) - 3'h1);
      for (int s = 0; s < NUM_PODS; s++)
      begin
         // explicit order or ascending pod numbers
         who = useOrder ? order[rep_pkg::ORDER_NIB*s +: PID_W] : PID_W'(s);
         // slot s: lane s mod L, range s div L
         if ((4'(s) < used) && (TA_W'(s >> lgL) == rng) && (who == pod))
         begin
            res = {1'b1, 2'(s) & lmask};
         end
      end
      return res;
   endfunction : map_pod

   // ****************************************************************
   // pin synchronisers
   // ****************************************************************
   logic [3:0] pinRaw;
   logic [3:0] s1_ff, s2_ff, s3_ff, filt_ff;
   logic [3:0] nxt_s1, nxt_s2, nxt_s3, nxt_filt;
   logic       ceOn, oeOn, wrOn;

   assign pinRaw = {~tgtCeN, ~tgtOeN, ~tgtPodWrN, ~tgtExtWrN};

   always_comb
   begin
      nxt_s1   = pinRaw;
      nxt_s2   = s1_ff;
      nxt_s3   = s2_ff;
      nxt_filt = (~(s2_ff ^ s3_ff) & s3_ff) | ((s2_ff ^ s3_ff) & filt_ff);
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         s1_ff   <= 4'h0;
         s2_ff   <= 4'h0;
         s3_ff   <= 4'h0;
         filt_ff <= 4'h0;
      end
      else
      begin
         s1_ff   <= nxt_s1;
         s2_ff   <= nxt_s2;
         s3_ff   <= nxt_s3;
         filt_ff <= nxt_filt;
      end
   end

   assign ceOn = filt_ff[3];
   assign oeOn = filt_ff[2];
   assign wrOn = filt_ff[1] | filt_ff[0];

   // ****************************************************************
   // configuration registers
   // ****************************************************************
   logic [31:0] ctrl_ff, base_ff, order_ff, group_ff, inspAddr_ff, mbxAddr_ff;
   logic [31:0] nxt_ctrl, nxt_base, nxt_order, nxt_group, nxt_inspAddr, nxt_mbxAddr;
   logic [7:0]  mbxData_ff, nxt_mbxData;
   logic [15:0] accCnt_ff, refCnt_ff, nxt_accCnt, nxt_refCnt;
   logic [31:0] rdata_ff, nxt_rdata;
   logic        cfgEn, mbxGo;
   logic        writable, staticMode, useOrder;
   rep_pkg::rep_romtype_t romType;
   logic [1:0]  lgL;
   logic [4:0]  dlg;
   logic [3:0]  used;
   logic        isPair, isX16, isRo;
   logic [7:0]  inspByte;
   logic        wrEnd, writeOk;

   assign cfgEn = (group_ff == 32'(GROUP_ID));
   assign mbxGo = regWr && (regAddr == rep_pkg::REG_MBX_DATA);

   // ****************************************************************
   // geometry decode
   // ****************************************************************
   always_comb
   begin
      writable   = ctrl_ff[rep_pkg::CTRL_WRITABLE_BIT];
      staticMode = ctrl_ff[rep_pkg::CTRL_STATIC_BIT];
      useOrder   = ctrl_ff[rep_pkg::CTRL_ORDER_BIT];
      romType    = rep_pkg::rep_romtype_t'(ctrl_ff[rep_pkg::CTRL_TYPE_LSB +: 3]);
      dlg        = rep_pkg::ROM_DEPTH_LG[romType];
      isX16      = rep_pkg::ROM_X16_MASK[romType];
      isPair     = rep_pkg::ROM_PAIR_MASK[romType];
      isRo       = rep_pkg::ROM_RO_MASK[romType];
      unique case (ctrl_ff[rep_pkg::CTRL_WSIZE_LSB +: 2])
         2'h0:    lgL = 2'h0;
         2'h1:    lgL = 2'h1;
         default: lgL = 2'h2;
      endcase
      if (isX16 && (lgL == 2'h0))
      begin
         lgL = 2'h1;
      end
      // two pods per socket plug
      used = isPair ? 4'({ctrl_ff[rep_pkg::CTRL_COUNT_LSB +: 3], 1'b0})
                    : 4'(ctrl_ff[rep_pkg::CTRL_COUNT_LSB +: 3]);
   end

   // ****************************************************************
   // target write capture
   // ****************************************************************
   logic            wrPrev_ff, oeSeen_ff, nxt_wrPrev, nxt_oeSeen;
   logic [TA_W-1:0] capAddr_ff, nxt_capAddr;
   logic [31:0]     capData_ff, nxt_capData;
   logic            wrLive;

   assign wrLive = wrOn & ceOn;

   always_comb
   begin
      nxt_wrPrev  = wrLive;
      nxt_capAddr = wrLive ? tgtAddr : capAddr_ff;
      nxt_capData = wrLive ? tgtDataIn : capData_ff;
      nxt_oeSeen  = wrLive & ((wrPrev_ff & oeSeen_ff) | oeOn);
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         wrPrev_ff  <= 1'b0;
         oeSeen_ff  <= 1'b0;
         capAddr_ff <= '0;
         capData_ff <= 32'h0000_0000;
      end
      else
      begin
         wrPrev_ff  <= nxt_wrPrev;
         oeSeen_ff  <= nxt_oeSeen;
         capAddr_ff <= nxt_capAddr;
         capData_ff <= nxt_capData;
      end
   end

   // commit at the trailing edge of the write strobe
   assign wrEnd   = wrPrev_ff & ~wrLive;
   assign writeOk = wrEnd & writable
                  & ~isRo
                  & (~oeSeen_ff | staticMode);

   // ****************************************************************
   // pod ports
   // ****************************************************************
   logic [TA_W-1:0] aWord, bWord;
   logic [31:0]     bDiff;
   logic [1:0]      bLane;
   logic [TA_W-1:0] offMask;
   logic [7:0]      podRdA [NUM_PODS];
   logic [7:0]      podRdB [NUM_PODS];
   logic [2:0]      mapA [NUM_PODS];
   logic [2:0]      mapB [NUM_PODS];
   logic [2:0]      mapA_ff [NUM_PODS];
   logic            hitB_ff [NUM_PODS];
   logic [31:0]     dataOut_ff, nxt_dataOut;
   logic            dataOe_ff, nxt_dataOe;

   assign aWord   = wrEnd ? capAddr_ff : tgtAddr;
   assign offMask = TA_W'((TA_W+1)'(1) << dlg) - TA_W'(1);
   // software addresses are the target's byte addresses offset by base_ff
   assign bDiff   = (mbxGo ? mbxAddr_ff : inspAddr_ff) - base_ff;
   assign bWord   = TA_W'(bDiff >> lgL);
   assign bLane   = 2'(bDiff) & 2'(3'(3'h1 << lgL) - 3'h1);

   for (genvar g = 0; g < NUM_PODS; g++)
   begin : gPod
      rep_mem_if #(.AW(POD_AW)) memIf ();

      rep_pod_mem #(.AW(POD_AW)) uMem (
         .mclk    (mclk),
         .memPort (memIf.mem)
      );

      assign mapA[g]         = map_pod(aWord, PID_W'(g), lgL, dlg, used, order_ff, useOrder);
      assign mapB[g]         = map_pod(bWord, PID_W'(g), lgL, dlg, used, order_ff, useOrder);
      assign memIf.aAddr     = POD_AW'(aWord & offMask);
      assign memIf.aWe       = writeOk & mapA[g][2];
      assign memIf.aWdata    = 8'(capData_ff >> {mapA[g][1:0], 3'h0});
      assign memIf.bAddr     = POD_AW'(bWord & offMask);
      assign memIf.bWe       = mbxGo & mapB[g][2] & (mapB[g][1:0] == bLane);
      assign memIf.bWdata    = regWdata[7:0];
      assign podRdA[g]       = memIf.aRdata;
      assign podRdB[g]       = memIf.bRdata;

      always_ff @(posedge mclk)
      begin
         if (!rst_n)
         begin
            mapA_ff[g] <= 3'h0;
            hitB_ff[g] <= 1'b0;
         end
         else
         begin
            mapA_ff[g] <= mapA[g];
            hitB_ff[g] <= mapB[g][2] & (mapB[g][1:0] == bLane);
         end
      end
   end

   // ****************************************************************
   // read data assembly
   // ****************************************************************
   always_comb
   begin
      nxt_dataOut = 32'h0000_0000;
      inspByte    = 8'h00;
      for (int p = 0; p < NUM_PODS; p++)
      begin
         if (mapA_ff[p][2])
         begin
            nxt_dataOut = nxt_dataOut | (32'(podRdA[p]) << {mapA_ff[p][1:0], 3'h0});
         end
         if (hitB_ff[p])
         begin
            inspByte = inspByte | podRdB[p];
         end
      end
      // flash mode serves a read even with write asserted
      nxt_dataOe = ceOn & oeOn & ~(wrLive & staticMode);
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         dataOut_ff <= 32'h0000_0000;
         dataOe_ff  <= 1'b0;
      end
      else
      begin
         dataOut_ff <= nxt_dataOut;
         dataOe_ff  <= nxt_dataOe;
      end
   end

   assign tgtDataOut = dataOut_ff;
   assign tgtDataOe  = dataOe_ff;

   // ****************************************************************
   // register file
   // ****************************************************************
   always_comb
   begin
      nxt_ctrl     = ctrl_ff;
      nxt_base     = base_ff;
      nxt_order    = order_ff;
      nxt_group    = group_ff;
      nxt_inspAddr = inspAddr_ff;
      nxt_mbxAddr  = mbxAddr_ff;
      nxt_mbxData  = mbxData_ff;
      nxt_accCnt   = accCnt_ff + 16'(writeOk);
      nxt_refCnt   = refCnt_ff + 16'(wrEnd & ~writeOk);
      nxt_rdata    = 32'h0000_0000;
      if (regWr)
      begin
         unique case (regAddr)
            rep_pkg::REG_CTRL:      if (cfgEn) nxt_ctrl = regWdata;
            rep_pkg::REG_BASE:      if (cfgEn) nxt_base = regWdata;
            rep_pkg::REG_ORDER:     if (cfgEn) nxt_order = regWdata;
            rep_pkg::REG_GROUP:     nxt_group = regWdata;
            rep_pkg::REG_INSP_ADDR: nxt_inspAddr = regWdata;
            rep_pkg::REG_MBX_ADDR:  nxt_mbxAddr = regWdata;
            rep_pkg::REG_MBX_DATA:  nxt_mbxData = regWdata[7:0];
            default:                nxt_mbxData = mbxData_ff;
         endcase
      end
      if (regRd)
      begin
         unique case (regAddr)
            rep_pkg::REG_CTRL:      nxt_rdata = ctrl_ff;
            rep_pkg::REG_BASE:      nxt_rdata = base_ff;
            rep_pkg::REG_ORDER:     nxt_rdata = order_ff;
            rep_pkg::REG_GROUP:     nxt_rdata = group_ff;
            rep_pkg::REG_INSP_ADDR: nxt_rdata = inspAddr_ff;
            rep_pkg::REG_INSP_DATA: nxt_rdata = {24'h00_0000, inspByte};
            rep_pkg::REG_MBX_ADDR:  nxt_rdata = mbxAddr_ff;
            rep_pkg::REG_MBX_DATA:  nxt_rdata = {24'h00_0000, mbxData_ff};
            rep_pkg::REG_STATUS:    nxt_rdata = {refCnt_ff, accCnt_ff};
            default:                nxt_rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         ctrl_ff     <= rep_pkg::CTRL_RST;
         base_ff     <= rep_pkg::BASE_RST;
         order_ff    <= rep_pkg::ORDER_RST;
         group_ff    <= rep_pkg::GROUP_RST;
         inspAddr_ff <= 32'h0000_0000;
         mbxAddr_ff  <= 32'h0000_0000;
         mbxData_ff  <= 8'h00;
         accCnt_ff   <= 16'h0000;
         refCnt_ff   <= 16'h0000;
         rdata_ff    <= 32'h0000_0000;
      end
      else
      begin
         ctrl_ff     <= nxt_ctrl;
         base_ff     <= nxt_base;
         order_ff    <= nxt_order;
         group_ff    <= nxt_group;
         inspAddr_ff <= nxt_inspAddr;
         mbxAddr_ff  <= nxt_mbxAddr;
         mbxData_ff  <= nxt_mbxData;
         accCnt_ff   <= nxt_accCnt;
         refCnt_ff   <= nxt_refCnt;
         rdata_ff    <= nxt_rdata;
      end
   end

   assign regRdata = rdata_ff;

endmodule : rep_pod_map

/* File: tb/rep_pod_map_chk.sv */
`timescale 1ns/1ps
module rep_pod_map_chk #(
   parameter int TA_W = 20
) (
   input wire logic            mclk,
   input wire logic            rst_n,
   input wire logic [7:0]      regAddr,
   input wire logic [31:0]     regWdata,
   input wire logic            regWr,
   input wire logic            regRd,
   input wire logic [31:0]     regRdata,
   input wire logic [TA_W-1:0] tgtAddr,
   input wire logic [31:0]     tgtDataIn,
   input wire logic [31:0]     tgtDataOut,
   input wire logic            tgtDataOe,
   input wire logic            tgtCeN,
   input wire logic            tgtOeN,
   input wire logic            tgtPodWrN,
   input wire logic            tgtExtWrN
);
   // ****************************************************************
   // shadow of the configuration registers
   // ****************************************************************
   logic [31:0] ctrl_ff, base_ff, order_ff, grp_ff;
   logic [31:0] nxt_ctrl, nxt_base, nxt_order, nxt_grp;
   logic        cfgOk;
   logic        wrOe;

   always_comb
   begin
      cfgOk     = regWr && (grp_ff == 32'(rep_pkg::GROUP_ID));
      nxt_grp   = (regWr && regAddr == rep_pkg::REG_GROUP) ? regWdata : grp_ff;
      nxt_ctrl  = (cfgOk && regAddr == rep_pkg::REG_CTRL) ? regWdata : ctrl_ff;
      nxt_base  = (cfgOk && regAddr == rep_pkg::REG_BASE) ? regWdata : base_ff;
      nxt_order = (cfgOk && regAddr == rep_pkg::REG_ORDER) ? regWdata : order_ff;
      wrOe      = !tgtCeN && !tgtOeN && !tgtPodWrN;
   end

   always_ff @(posedge mclk)
   begin
      grp_ff   <= rst_n ? nxt_grp : rep_pkg::GROUP_RST;
      ctrl_ff  <= rst_n ? nxt_ctrl : rep_pkg::CTRL_RST;
      base_ff  <= rst_n ? nxt_base : rep_pkg::BASE_RST;
      order_ff <= rst_n ? nxt_order : rep_pkg::ORDER_RST;
   end

   // ****************************************************************
   // properties
   // ****************************************************************
   default clocking dcb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);

   a_rd_idle_zero: assert property (!$past(regRd) |-> regRdata == 32'h0)
      else $error("read data not zero outside a read answer");
   a_ctrl_readback: assert property (
      regRd && regAddr == rep_pkg::REG_CTRL |=> regRdata[10:0] == ctrl_ff[10:0])
      else $error("control readback differs");
   a_base_readback: assert property (
      regRd && regAddr == rep_pkg::REG_BASE |=> regRdata == base_ff)
      else $error("base readback differs");
   a_order_readback: assert property (
      regRd && regAddr == rep_pkg::REG_ORDER |=> regRdata == order_ff)
      else $error("order readback differs");
   a_group_readback: assert property (
      regRd && regAddr == rep_pkg::REG_GROUP |=> regRdata[3:0] == grp_ff[3:0])
      else $error("group readback differs");
   a_idle_no_drive: assert property (tgtCeN [*8] |-> !tgtDataOe)
      else $error("data bus driven while deselected");
   a_flash_wr_reads: assert property (
      (wrOe && !ctrl_ff[rep_pkg::CTRL_STATIC_BIT]) [*8] |-> tgtDataOe)
      else $error("write with output enable not served as read");
   a_static_wr_quiet: assert property (
      (wrOe && ctrl_ff[rep_pkg::CTRL_STATIC_BIT]) [*8] |-> !tgtDataOe)
      else $error("static write with output enable drove the bus");

   c_reg_read: cover property (regRd && regAddr == rep_pkg::REG_CTRL);
   c_tgt_read: cover property ($rose(tgtDataOe));
   c_static_wr: cover property (wrOe && ctrl_ff[rep_pkg::CTRL_STATIC_BIT]);
endmodule : rep_pod_map_chk

bind rep_pod_map rep_pod_map_chk #(.TA_W(TA_W)) i_rep_pod_map_chk (.mclk(mclk), .rst_n(rst_n),
   .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
   .regRdata(regRdata), .tgtAddr(tgtAddr), .tgtDataIn(tgtDataIn), .tgtDataOut(tgtDataOut),
   .tgtDataOe(tgtDataOe), .tgtCeN(tgtCeN), .tgtOeN(tgtOeN), .tgtPodWrN(tgtPodWrN),
   .tgtExtWrN(tgtExtWrN));

/* File: tb/rep_tgt_model.sv */
`timescale 1ns/1ps
module rep_tgt_model #(
   parameter int TA_W = 20
) (
   input  wire logic            mclk,
   output logic      [TA_W-1:0] tgtAddr,
   output logic      [31:0]     tgtDataIn,
   input  wire logic [31:0]     tgtDataOut,
   input  wire logic            tgtDataOe,
   output logic                 tgtCeN,
   output logic                 tgtOeN,
   output logic                 tgtPodWrN,
   output logic                 tgtExtWrN
);
   initial
   begin
      tgtAddr   = '0;
      tgtDataIn = 32'h0;
      tgtCeN    = 1'b1;
      tgtOeN    = 1'b1;
      tgtPodWrN = 1'b1;
      tgtExtWrN = 1'b1;
   end

   // mode: [2] output enable, [1] external write, [0] pod write
   task automatic cycle(input logic [TA_W-1:0] a, input logic [31:0] d, input logic [2:0] m,
                        output logic [31:0] q, output logic oe);
      @(posedge mclk);
      tgtAddr   <= a;
      tgtDataIn <= d;
      tgtCeN    <= 1'b0;
      tgtOeN    <= ~m[2];
      tgtExtWrN <= ~m[1];
      tgtPodWrN <= ~m[0];
      // strobes held well past the pin filter, like a slow bus cycle
      repeat (10) @(posedge mclk);
      #1;
      q  = tgtDataOut;
      oe = tgtDataOe;
      @(posedge mclk);
      tgtCeN    <= 1'b1;
      tgtOeN    <= 1'b1;
      tgtExtWrN <= 1'b1;
      tgtPodWrN <= 1'b1;
      // write data held until the late synchronised commit has taken it
      repeat (8) @(posedge mclk);
      tgtDataIn <= ~d;
   endtask : cycle
endmodule : rep_tgt_model

/* File: tb/rep_pod_map_tb_top.sv */
`timescale 1ns/1ps
module rep_pod_map_tb_top;
   localparam logic [2:0] RD  = 3'h4;
   localparam logic [2:0] PW  = 3'h1;
   localparam logic [2:0] EW  = 3'h2;
   localparam logic [2:0] OPW = 3'h5;
   logic        mclk = 1'b0;
   logic        rst_n = 1'b0;
   logic [7:0]  regAddr = 8'h00;
   logic [31:0] regWdata = 32'h0;
   logic        regWr = 1'b0;
   logic        regRd = 1'b0;
   logic [31:0] regRdata, tgtDataIn, tgtDataOut, q, v, s0;
   logic [19:0] tgtAddr;
   logic        tgtDataOe, tgtCeN, tgtOeN, tgtPodWrN, tgtExtWrN, oe;
   int          n_mismatch = 0;
   int          n_compared = 0;

   always #2.5 mclk = ~mclk;

   rep_pod_map i_rep_pod_map (.mclk(mclk), .rst_n(rst_n), .regAddr(regAddr),
      .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
      .tgtAddr(tgtAddr), .tgtDataIn(tgtDataIn), .tgtDataOut(tgtDataOut),
      .tgtDataOe(tgtDataOe), .tgtCeN(tgtCeN), .tgtOeN(tgtOeN), .tgtPodWrN(tgtPodWrN),
      .tgtExtWrN(tgtExtWrN));
   rep_tgt_model i_rep_tgt_model (.mclk(mclk), .tgtAddr(tgtAddr), .tgtDataIn(tgtDataIn),
      .tgtDataOut(tgtDataOut), .tgtDataOe(tgtDataOe), .tgtCeN(tgtCeN), .tgtOeN(tgtOeN),
      .tgtPodWrN(tgtPodWrN), .tgtExtWrN(tgtExtWrN));

   // ****************************************************************
   // shared tasks
   // ****************************************************************
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic regW(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      regAddr  <= a;
      regWdata <= d;
      regWr    <= 1'b1;
      @(posedge mclk);
      regWr    <= 1'b0;
   endtask : regW

   task automatic regR(input logic [7:0] a, output logic [31:0] d);
      @(posedge mclk);
      regAddr <= a;
      regRd   <= 1'b1;
      @(posedge mclk);
      regRd   <= 1'b0;
      #1;
      d = regRdata;
   endtask : regR

   task automatic tw(input logic [19:0] a, input logic [31:0] d, input logic [2:0] m);
      i_rep_tgt_model.cycle(a, d, m, q, oe);
   endtask : tw

   task automatic trd(input logic [19:0] a, input logic [31:0] mask, input logic [31:0] e);
      i_rep_tgt_model.cycle(a, 32'h0, RD, q, oe);
      chk("target word", q & mask, e);
      chk("target drive", {31'h0, oe}, 32'h1);
   endtask : trd

   function automatic logic [31:0] ctl(input int t, input int w, input int c, input int fl);
      return 32'(fl) | (32'(t) << rep_pkg::CTRL_TYPE_LSB)
         | (32'(w) << rep_pkg::CTRL_WSIZE_LSB) | (32'(c) << rep_pkg::CTRL_COUNT_LSB);
   endfunction : ctl

   // ****************************************************************
   // scenarios
   // ****************************************************************
   task automatic t_regs();
      regR(rep_pkg::REG_CTRL, v);
      chk("ctrl reset", v, rep_pkg::CTRL_RST);
      regR(rep_pkg::REG_ORDER, v);
      chk("order reset", v, rep_pkg::ORDER_RST);
      regR(8'h24, v);
      chk("unmapped read", v, 32'h0);
      regW(rep_pkg::REG_GROUP, 32'h1);
      regW(rep_pkg::REG_CTRL, 32'h1);
      regR(rep_pkg::REG_CTRL, v);
      chk("ctrl other group", v, rep_pkg::CTRL_RST);
      regW(rep_pkg::REG_GROUP, 32'h0);
      $display("test regs done");
   endtask : t_regs

   task automatic t_map();
      regW(rep_pkg::REG_CTRL, ctl(0, 0, 4, 1));
      tw(20'h00010, 32'hA5, PW);
      tw(20'h08010, 32'h3C, PW);
      tw(20'h10010, 32'h5A, PW);
      tw(20'h18010, 32'hC3, PW);
      trd(20'h08010, 32'hFF, 32'h3C);
      regW(rep_pkg::REG_CTRL, ctl(0, 1, 4, 1));
      trd(20'h00010, 32'hFFFF, 32'h3CA5);
      trd(20'h08010, 32'hFFFF, 32'hC35A);
      regW(rep_pkg::REG_CTRL, ctl(0, 2, 4, 1));
      trd(20'h00010, 32'hFFFF_FFFF, 32'hC35A_3CA5);
      regW(rep_pkg::REG_ORDER, 32'h7654_0123);
      regW(rep_pkg::REG_CTRL, ctl(0, 2, 4, 32'h401));
      trd(20'h00010, 32'hFFFF_FFFF, 32'hA53C_5AC3);
      $display("test map done");
   endtask : t_map

   task automatic t_perm();
      regR(rep_pkg::REG_STATUS, s0);
      regW(rep_pkg::REG_CTRL, ctl(0, 0, 1, 1));
      tw(20'h00020, 32'h11, PW);
      regW(rep_pkg::REG_CTRL, ctl(0, 0, 1, 0));
      tw(20'h00020, 32'h22, EW);
      trd(20'h00020, 32'hFF, 32'h11);
      regW(rep_pkg::REG_CTRL, ctl(0, 0, 1, 1));
      tw(20'h00020, 32'h33, EW);
      trd(20'h00020, 32'hFF, 32'h33);
      regW(rep_pkg::REG_CTRL, ctl(4, 0, 1, 1));
      tw(20'h00020, 32'h44, PW);
      tw(20'h00020, 32'h45, EW);
      trd(20'h00020, 32'hFF, 32'h33);
      regW(rep_pkg::REG_MBX_ADDR, 32'h20);
      regW(rep_pkg::REG_MBX_DATA, 32'h55);
      trd(20'h00020, 32'hFF, 32'h55);
      regR(rep_pkg::REG_STATUS, v);
      chk("status delta", v - s0, 32'h0003_0002);
      regW(rep_pkg::REG_CTRL, ctl(5, 0, 1, 1));
      tw(20'h00020, 32'hBEEF, PW);
      trd(20'h00020, 32'hFFFF, 32'hBEEF);
      regW(rep_pkg::REG_CTRL, ctl(7, 0, 1, 1));
      tw(20'h00020, 32'h1234, PW);
      trd(20'h00020, 32'hFFFF, 32'hBEEF);
      $display("test permission done");
   endtask : t_perm

   task automatic t_oe();
      regW(rep_pkg::REG_CTRL, ctl(0, 0, 1, 1));
      tw(20'h00020, 32'h66, OPW);
      chk("flash both data", q & 32'hFF, 32'hEF);
      chk("flash both drive", {31'h0, oe}, 32'h1);
      trd(20'h00020, 32'hFF, 32'hEF);
      regW(rep_pkg::REG_CTRL, ctl(0, 0, 1, 3));
      tw(20'h00020, 32'h77, OPW);
      chk("static both drive", {31'h0, oe}, 32'h0);
      trd(20'h00020, 32'hFF, 32'h77);
      $display("test output enable done");
   endtask : t_oe

   task automatic t_base();
      regR(rep_pkg::REG_BASE, v);
      chk("base reset", v, rep_pkg::BASE_RST);
      regW(rep_pkg::REG_BASE, 32'h1000_0000);
      regW(rep_pkg::REG_INSP_ADDR, 32'h1000_0020);
      repeat (2) @(posedge mclk);
      regR(rep_pkg::REG_INSP_DATA, v);
      chk("inspect byte", v & 32'hFF, 32'h77);
      $display("test base done");
   endtask : t_base

   task automatic end_of_test();
      $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : end_of_test

   initial
   begin
      repeat (3) @(posedge mclk);
      rst_n <= 1'b1;
      t_regs();
      t_map();
      t_perm();
      t_oe();
      t_base();
      end_of_test();
   end

   initial
   begin
      repeat (20000) @(posedge mclk);
      n_mismatch++;
      end_of_test();
   end
endmodule : rep_pod_map_tb_top
